// [adc2_byte_mem.sv]
`timescale 1ns/10ps
module adc2_byte_mem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdData_r;
  logic [DW-1:0] rdData_nxt;

  always_comb
  begin
    rdData_nxt = mem[rdAddr];
  end

  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    if (reset)
    begin
      rdData_r <= '0;
    end
    else
    begin
      rdData_r <= rdData_nxt;
    end
  end

  assign rdData = rdData_r;
endmodule : adc2_byte_mem

// [adc2_clk_div.sv]
`timescale 1ns/10ps
module adc2_clk_div (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic useOsc,
  input wire logic oscTick,
  input wire logic [5:0] divisor,
  output logic convClkTick
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic divTick;

  always_comb
  begin
    divTick = enable && (cnt_r >= divisor);
    if (!enable || divTick)
    begin
      cnt_nxt = adc2_pkg::RST_DIV_CNT;
    end
    else
    begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cnt_r <= adc2_pkg::RST_DIV_CNT;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign convClkTick = enable && (useOsc ? oscTick : divTick);
endmodule : adc2_clk_div

// [adc2_ctrl_properties.sv]
`timescale 1ns/10ps
module adc2_ctrl_properties (
  input wire logic clock,
  input wire logic reset,
  input wire logic [11:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [7:0] busRdata,
  input wire logic convDone,
  input wire logic [9:0] convData,
  input wire logic thresholdInterruptFlag,
  input wire logic accClearDone,
  input wire logic oscTick,
  input wire adc2_pkg::adc2_comp_in_t compIn,
  input wire adc2_pkg::adc2_ctl_out_t ctlOut,
  input wire adc2_pkg::adc2_acc_wr_t accWr
);
  logic mainWr;
  logic contMode_r;
  logic contMode_nxt;
  logic stopInt_r;
  logic stopInt_nxt;
  logic clkSel_r;
  logic clkSel_nxt;
  assign mainWr = busWrite && busAddr == adc2_pkg::ADDR_MAIN_CTL;
  // Shadow of the mode bits software last wrote
  always_comb
  begin
    contMode_nxt = contMode_r;
    clkSel_nxt = clkSel_r;
    stopInt_nxt = stopInt_r;
    if (mainWr)
    begin
      contMode_nxt = busWdata[6];
      clkSel_nxt = busWdata[4];
    end
    if (busWrite && busAddr == adc2_pkg::ADDR_THR_CTL)
      stopInt_nxt = busWdata[3];
  end
  always_ff @(posedge clock)
  begin
    contMode_r <= reset ? 1'b0 : contMode_nxt;
    clkSel_r <= reset ? 1'b0 : clkSel_nxt;
    stopInt_r <= reset ? 1'b0 : stopInt_nxt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  rd_idle_a: assert property (!$past(busRead) |-> busRdata == 8'h00)
    else $error("read data not zero outside read cycle");
  start_go_a: assert property (mainWr && busWdata[7] && busWdata[0] && !ctlOut.enable
    |=> ctlOut.start) else $error("go write did not start");
  off_no_start_a: assert property (mainWr && !busWdata[7]
    |=> !ctlOut.enable && !ctlOut.start && !ctlOut.convClkTick) else $error("disabled runs");
  osc_clock_a: assert property (ctlOut.enable && clkSel_r |-> ctlOut.convClkTick == oscTick)
    else $error("conversion clock not oscillator");
  pair_hold_a: assert property (convDone && ctlOut.doubleSampleEnable && !ctlOut.secondOfPair
    |=> !ctlOut.computeStrobe) else $error("computed after first of pair");
  pair_done_a: assert property (convDone && ctlOut.secondOfPair && !busWrite
    |-> ##[1:2] ctlOut.computeStrobe) else $error("no compute after pair");
  retrigger_a: assert property (ctlOut.computeStrobe && contMode_r && !busWrite
    && !(stopInt_r && thresholdInterruptFlag) |-> ##[1:2] ctlOut.start) else $error("no rearm");
  int_stop_a: assert property (ctlOut.computeStrobe && contMode_r && stopInt_r
    && thresholdInterruptFlag && !busWrite |=> !ctlOut.start
    ##1 (!ctlOut.start || $past(busWrite))) else $error("rearm on flag");
  single_stop_a: assert property (ctlOut.computeStrobe && !contMode_r && !busWrite
    |=> !ctlOut.start ##1 (!ctlOut.start || $past(busWrite))) else $error("single mode rearmed");
  pre_guard_a: assert property (busWrite && busAddr == adc2_pkg::ADDR_PRE_GUARD |=>
    {ctlOut.prechargePolarity, ctlOut.invertedPrechargeEnable, ctlOut.guardRingPolarity,
    ctlOut.doubleSampleEnable} == {$past(busWdata[7:5]), $past(busWdata[0])})
    else $error("precharge fields wrong");
  comp_ctl_a: assert property (busWrite && busAddr == adc2_pkg::ADDR_COMP_CTL |=>
    {ctlOut.previousSampleSource, ctlOut.rightShiftCount, ctlOut.operatingMode}
    == {$past(busWdata[7:4]), $past(busWdata[2:0])}) else $error("computation fields wrong");
  cov_pair: cover property (convDone && ctlOut.secondOfPair);
  cov_stop: cover property (ctlOut.computeStrobe && stopInt_r && thresholdInterruptFlag);
  cov_rearm: cover property (ctlOut.computeStrobe && contMode_r ##[1:2] ctlOut.start);
endmodule : adc2_ctrl_properties

bind adc2_ctrl_regs adc2_ctrl_properties u_props (.clock, .reset, .busAddr, .busWdata,
  .busWrite, .busRead, .busRdata, .convDone, .convData, .thresholdInterruptFlag,
  .accClearDone, .oscTick, .compIn, .ctlOut, .accWr);

// [adc2_ctrl_regs.sv]
// Contract
// - Registers span 0xF51 to 0xF6E, little-endian words
// - Main control bits: enable, continuous, clock, format, go
// - Enable bit runs or disables the converter
// - Writing go starts; reads one while busy
// - Go reads zero when idle or done
// - Continuous mode rearms go after each conversion
// - Retrigger stops on flag or software clear
// - Single mode clears go after conversion
// - Clock select one uses dedicated conversion oscillator
// - Clock select zero divides system clock
// - Format selects right or left justified results
// - Precharge/guard register bits 7,6,5,0, reset zero
// - Double-sample pairs conversions, computes every second
// - Stop-on-interrupt lets hardware clear go
// - Computation control fields: source, shift, clear, mode
`timescale 1ns/10ps
module adc2_ctrl_regs (
  input wire logic clock,
  input wire logic reset,
  input wire logic [11:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [7:0] busRdata,
  input wire logic convDone,
  input wire logic [9:0] convData,
  input wire logic thresholdInterruptFlag,
  input wire logic accClearDone,
  input wire logic oscTick,
  input wire adc2_pkg::adc2_comp_in_t compIn,
  output adc2_pkg::adc2_ctl_out_t ctlOut,
  output adc2_pkg::adc2_acc_wr_t accWr
);
  logic [7:0] main_r;
  logic [7:0] main_nxt;
  logic [7:0] preGuard_r;
  logic [7:0] preGuard_nxt;
  logic [7:0] comp_r;
  logic [7:0] comp_nxt;
  logic [7:0] thr_r;
  logic [7:0] thr_nxt;
  logic [5:0] clkDiv_r;
  logic [5:0] clkDiv_nxt;
  logic [9:0] result_r;
  logic [9:0] result_nxt;
  logic [15:0] prev_r;
  logic [15:0] prev_nxt;
  logic prevFilt_r;
  logic prevFilt_nxt;
  logic pair_r;
  logic pair_nxt;
  logic start_r;
  logic start_nxt;
  logic compute_r;
  logic compute_nxt;
  adc2_pkg::adc2_state_t state_r;
  adc2_pkg::adc2_state_t state_nxt;
  adc2_pkg::adc2_acc_wr_t accWr_r;
  adc2_pkg::adc2_acc_wr_t accWr_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic memSel_r;
  logic memSel_nxt;
  logic [7:0] memQ;
  logic [7:0] memMask;
  logic [7:0] memWdata;
  logic memWrite;
  logic [4:0] memIdx;
  logic mainWrite;
  logic goSet;
  logic goClr;
  logic enableNxt;
  logic retrigger;
  logic [15:0] resView;
  logic [15:0] prevView;

  function automatic logic [15:0] justify(input logic [9:0] raw, input logic right);
    justify = right ? {6'h00, raw} : {raw, 6'h00};
  endfunction : justify

  assign memIdx = 5'(busAddr - adc2_pkg::ADDR_BASE);

  always_comb
  begin
    case (busAddr)
      adc2_pkg::ADDR_AUTO_TRIG: memMask = adc2_pkg::MASK_AUTO_TRIG;
      adc2_pkg::ADDR_REF_SEL: memMask = adc2_pkg::MASK_REF;
      adc2_pkg::ADDR_ACQ_TIME: memMask = adc2_pkg::MASK_FULL;
      adc2_pkg::ADDR_EXTRA_CAP: memMask = adc2_pkg::MASK_CAP;
      adc2_pkg::ADDR_PRE_TIME: memMask = adc2_pkg::MASK_FULL;
      adc2_pkg::ADDR_POS_CHAN: memMask = adc2_pkg::MASK_CHAN;
      adc2_pkg::ADDR_REPEAT: memMask = adc2_pkg::MASK_FULL;
      adc2_pkg::ADDR_SETPOINT,
      adc2_pkg::ADDR_SETPOINT + 12'h001,
      adc2_pkg::ADDR_LOWER_THR,
      adc2_pkg::ADDR_LOWER_THR + 12'h001,
      adc2_pkg::ADDR_UPPER_THR,
      adc2_pkg::ADDR_UPPER_THR + 12'h001: memMask = adc2_pkg::MASK_FULL;
      default: memMask = 8'h00;
    endcase
  end

  assign memWrite = busWrite && (memMask != 8'h00);
  assign memWdata = busWdata & memMask;
  assign mainWrite = busWrite && (busAddr == adc2_pkg::ADDR_MAIN_CTL);
  assign goSet = mainWrite && busWdata[adc2_pkg::BIT_GO];
  assign goClr = mainWrite && !busWdata[adc2_pkg::BIT_GO];

  adc2_byte_mem #(
    .AW(adc2_pkg::MEM_AW),
    .DW(8)
  ) u_mem (
    .clock(clock),
    .reset(reset),
    .wrEn(memWrite),
    .wrAddr(memIdx),
    .wrData(memWdata),
    .rdAddr(memIdx),
    .rdData(memQ)
  );

  adc2_clk_div u_div (
    .clock(clock),
    .reset(reset),
    .enable(main_r[adc2_pkg::BIT_ENABLE]),
    .useOsc(main_r[adc2_pkg::BIT_CLK_SEL]),
    .oscTick(oscTick),
    .divisor(clkDiv_r),
    .convClkTick(ctlOut.convClkTick)
  );

  assign resView = justify(result_r, main_r[adc2_pkg::BIT_FORMAT]);
  assign prevView = prevFilt_r ? prev_r : justify(prev_r[9:0], main_r[adc2_pkg::BIT_FORMAT]);

  always_comb
  begin
    main_nxt = main_r;
    preGuard_nxt = preGuard_r;
    comp_nxt = comp_r;
    thr_nxt = thr_r;
    clkDiv_nxt = clkDiv_r;
    result_nxt = result_r;
    prev_nxt = prev_r;
    prevFilt_nxt = prevFilt_r;
    pair_nxt = pair_r;
    state_nxt = state_r;
    start_nxt = 1'b0;
    compute_nxt = 1'b0;
    accWr_nxt = '0;
    retrigger = 1'b0;
    if (accClearDone)
    begin
      comp_nxt[adc2_pkg::BIT_ACC_CLR] = 1'b0;
    end
    if (busWrite)
    begin
      case (busAddr)
        adc2_pkg::ADDR_MAIN_CTL:
        begin
          main_nxt = (busWdata & adc2_pkg::MASK_MAIN) | (main_r & ~adc2_pkg::MASK_MAIN);
          main_nxt[adc2_pkg::BIT_GO] = main_r[adc2_pkg::BIT_GO];
        end
        adc2_pkg::ADDR_PRE_GUARD: preGuard_nxt = busWdata & adc2_pkg::MASK_PRE_GUARD;
        adc2_pkg::ADDR_COMP_CTL:
        begin
          comp_nxt = busWdata & adc2_pkg::MASK_COMP;
          if (accClearDone && !busWdata[adc2_pkg::BIT_ACC_CLR])
          begin
            comp_nxt[adc2_pkg::BIT_ACC_CLR] = 1'b0;
          end
        end
        adc2_pkg::ADDR_THR_CTL: thr_nxt = busWdata & adc2_pkg::MASK_THR;
        adc2_pkg::ADDR_CLK_DIV: clkDiv_nxt = busWdata[5:0];
        adc2_pkg::ADDR_ACCUM, adc2_pkg::ADDR_ACCUM + 12'h001:
        begin
          accWr_nxt.valid = 1'b1;
          accWr_nxt.highByte = busAddr[0] == adc2_pkg::ADDR_ACCUM[0] ? 1'b0 : 1'b1;
          accWr_nxt.data = busWdata;
        end
        default:
        begin
          main_nxt = main_nxt;
        end
      endcase
    end
    enableNxt = main_nxt[adc2_pkg::BIT_ENABLE];
    case (state_r)
      adc2_pkg::ADC2_IDLE:
      begin
        if (goSet && enableNxt)
        begin
          main_nxt[adc2_pkg::BIT_GO] = 1'b1;
          retrigger = 1'b1;
        end
        else
        begin
          main_nxt[adc2_pkg::BIT_GO] = 1'b0;
        end
      end
      adc2_pkg::ADC2_RUN:
      begin
        if (convDone)
        begin
          result_nxt = convData;
          compute_nxt = !preGuard_r[adc2_pkg::BIT_DOUBLE] || pair_r;
          pair_nxt = preGuard_r[adc2_pkg::BIT_DOUBLE] && !pair_r;
          state_nxt = adc2_pkg::ADC2_EVAL;
        end
      end
      adc2_pkg::ADC2_EVAL:
      begin
        if (main_r[adc2_pkg::BIT_CONT])
        begin
          retrigger = !(thr_r[adc2_pkg::BIT_STOP_INT] && thresholdInterruptFlag);
        end
        retrigger = retrigger || goSet;
        main_nxt[adc2_pkg::BIT_GO] = retrigger;
        if (!retrigger)
        begin
          state_nxt = adc2_pkg::ADC2_IDLE;
        end
      end
      default:
      begin
        state_nxt = adc2_pkg::ADC2_IDLE;
      end
    endcase
    if (state_r != adc2_pkg::ADC2_IDLE && goClr && !goSet)
    begin
      main_nxt[adc2_pkg::BIT_GO] = 1'b0;
      retrigger = 1'b0;
      state_nxt = adc2_pkg::ADC2_IDLE;
    end
    if (!enableNxt)
    begin
      main_nxt[adc2_pkg::BIT_GO] = 1'b0;
      retrigger = 1'b0;
      pair_nxt = 1'b0;
      state_nxt = adc2_pkg::ADC2_IDLE;
    end
    if (retrigger)
    begin
      start_nxt = 1'b1;
      state_nxt = adc2_pkg::ADC2_RUN;
      prevFilt_nxt = comp_r[adc2_pkg::BIT_PREV_SRC];
      prev_nxt = comp_r[adc2_pkg::BIT_PREV_SRC] ? compIn.filter : {6'h00, result_nxt};
    end
  end

  always_comb
  begin
    memSel_nxt = 1'b0;
    rd_nxt = 8'h00;
    case (busAddr)
      adc2_pkg::ADDR_CLK_DIV: rd_nxt = {2'b00, clkDiv_r};
      adc2_pkg::ADDR_PRE_GUARD: rd_nxt = preGuard_r;
      adc2_pkg::ADDR_COMP_CTL: rd_nxt = comp_r;
      adc2_pkg::ADDR_THR_CTL: rd_nxt = thr_r;
      adc2_pkg::ADDR_MAIN_CTL: rd_nxt = main_r;
      adc2_pkg::ADDR_PREV_RES: rd_nxt = prevView[7:0];
      adc2_pkg::ADDR_PREV_RES + 12'h001: rd_nxt = prevView[15:8];
      adc2_pkg::ADDR_CONV_RES: rd_nxt = resView[7:0];
      adc2_pkg::ADDR_CONV_RES + 12'h001: rd_nxt = resView[15:8];
      adc2_pkg::ADDR_COMP_STAT: rd_nxt = compIn.status;
      adc2_pkg::ADDR_SAMPLE_CNT: rd_nxt = compIn.count;
      adc2_pkg::ADDR_ERROR: rd_nxt = compIn.error[7:0];
      adc2_pkg::ADDR_ERROR + 12'h001: rd_nxt = compIn.error[15:8];
      adc2_pkg::ADDR_ACCUM: rd_nxt = compIn.accum[7:0];
      adc2_pkg::ADDR_ACCUM + 12'h001: rd_nxt = compIn.accum[15:8];
      adc2_pkg::ADDR_FILTER: rd_nxt = compIn.filter[7:0];
      adc2_pkg::ADDR_LAST: rd_nxt = compIn.filter[15:8];
      default:
      begin
        memSel_nxt = (memMask != 8'h00);
      end
    endcase
    if (!busRead)
    begin
      rd_nxt = 8'h00;
      memSel_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      main_r <= adc2_pkg::RST_BYTE;
      preGuard_r <= adc2_pkg::RST_BYTE;
      comp_r <= adc2_pkg::RST_BYTE;
      thr_r <= adc2_pkg::RST_BYTE;
      clkDiv_r <= adc2_pkg::RST_DIV_CNT;
      result_r <= 10'h000;
      prev_r <= adc2_pkg::RST_WORD;
      prevFilt_r <= 1'b0;
      pair_r <= 1'b0;
      start_r <= 1'b0;
      compute_r <= 1'b0;
      state_r <= adc2_pkg::ADC2_IDLE;
      accWr_r <= '0;
      rd_r <= adc2_pkg::RST_BYTE;
      memSel_r <= 1'b0;
    end
    else
    begin
      main_r <= main_nxt;
      preGuard_r <= preGuard_nxt;
      comp_r <= comp_nxt;
      thr_r <= thr_nxt;
      clkDiv_r <= clkDiv_nxt;
      result_r <= result_nxt;
      prev_r <= prev_nxt;
      prevFilt_r <= prevFilt_nxt;
      pair_r <= pair_nxt;
      start_r <= start_nxt;
      compute_r <= compute_nxt;
      state_r <= state_nxt;
      accWr_r <= accWr_nxt;
      rd_r <= rd_nxt;
      memSel_r <= memSel_nxt;
    end
  end

  assign busRdata = memSel_r ? (memQ & 8'hFF) : rd_r;
  assign accWr = accWr_r;
  assign ctlOut.enable = main_r[adc2_pkg::BIT_ENABLE];
  assign ctlOut.start = start_r;
  assign ctlOut.computeStrobe = compute_r;
  assign ctlOut.secondOfPair = pair_r;
  assign ctlOut.prechargePolarity = preGuard_r[adc2_pkg::BIT_PRE_POL];
  assign ctlOut.invertedPrechargeEnable = preGuard_r[adc2_pkg::BIT_INV_PRE];
  assign ctlOut.guardRingPolarity = preGuard_r[adc2_pkg::BIT_GUARD_POL];
  assign ctlOut.doubleSampleEnable = preGuard_r[adc2_pkg::BIT_DOUBLE];
  assign ctlOut.previousSampleSource = comp_r[adc2_pkg::BIT_PREV_SRC];
  assign ctlOut.rightShiftCount = comp_r[adc2_pkg::POS_SHIFT +: 3];
  assign ctlOut.accumulatorClearCommand = comp_r[adc2_pkg::BIT_ACC_CLR];
  assign ctlOut.operatingMode = comp_r[adc2_pkg::POS_MODE +: 3];
  assign ctlOut.errorCalcMode = thr_r[adc2_pkg::POS_CALC +: 3];
  assign ctlOut.thresholdMode = thr_r[adc2_pkg::POS_THR_MODE +: 3];
endmodule : adc2_ctrl_regs

// [adc2_pkg.sv]
package adc2_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_BASE = 12'hF51;
  localparam logic [11:0] ADDR_AUTO_TRIG = 12'hF51;
  localparam logic [11:0] ADDR_CLK_DIV = 12'hF52;
  localparam logic [11:0] ADDR_REF_SEL = 12'hF53;
  localparam logic [11:0] ADDR_PRE_GUARD = 12'hF54;
  localparam logic [11:0] ADDR_COMP_CTL = 12'hF55;
  localparam logic [11:0] ADDR_THR_CTL = 12'hF56;
  localparam logic [11:0] ADDR_ACQ_TIME = 12'hF57;
  localparam logic [11:0] ADDR_EXTRA_CAP = 12'hF58;
  localparam logic [11:0] ADDR_PRE_TIME = 12'hF59;
  localparam logic [11:0] ADDR_POS_CHAN = 12'hF5A;
  localparam logic [11:0] ADDR_MAIN_CTL = 12'hF5B;
  localparam logic [11:0] ADDR_PREV_RES = 12'hF5C;
  localparam logic [11:0] ADDR_CONV_RES = 12'hF5E;
  localparam logic [11:0] ADDR_COMP_STAT = 12'hF60;
  localparam logic [11:0] ADDR_REPEAT = 12'hF61;
  localparam logic [11:0] ADDR_SAMPLE_CNT = 12'hF62;
  localparam logic [11:0] ADDR_SETPOINT = 12'hF63;
  localparam logic [11:0] ADDR_LOWER_THR = 12'hF65;
  localparam logic [11:0] ADDR_UPPER_THR = 12'hF67;
  localparam logic [11:0] ADDR_ERROR = 12'hF69;
  localparam logic [11:0] ADDR_ACCUM = 12'hF6B;
  localparam logic [11:0] ADDR_FILTER = 12'hF6D;
  localparam logic [11:0] ADDR_LAST = 12'hF6E;
  localparam int MEM_AW = 5;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_CONT = 6;
  localparam int BIT_CLK_SEL = 4;
  localparam int BIT_FORMAT = 2;
  localparam int BIT_GO = 0;
  localparam int BIT_PRE_POL = 7;
  localparam int BIT_INV_PRE = 6;
  localparam int BIT_GUARD_POL = 5;
  localparam int BIT_DOUBLE = 0;
  localparam int BIT_PREV_SRC = 7;
  localparam int POS_SHIFT = 4;
  localparam int BIT_ACC_CLR = 3;
  localparam int POS_MODE = 0;
  localparam int POS_CALC = 4;
  localparam int BIT_STOP_INT = 3;
  localparam int POS_THR_MODE = 0;
  localparam logic [7:0] MASK_MAIN = 8'hD5;
  localparam logic [7:0] MASK_PRE_GUARD = 8'hE1;
  localparam logic [7:0] MASK_COMP = 8'hFF;
  localparam logic [7:0] MASK_THR = 8'h7F;
  localparam logic [7:0] MASK_AUTO_TRIG = 8'h1F;
  localparam logic [7:0] MASK_CLK_DIV = 8'h3F;
  localparam logic [7:0] MASK_REF = 8'h13;
  localparam logic [7:0] MASK_CAP = 8'h1F;
  localparam logic [7:0] MASK_CHAN = 8'h3F;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [5:0] RST_DIV_CNT = 6'h00;

  typedef enum logic [1:0] {
    ADC2_IDLE = 2'b00,
    ADC2_RUN = 2'b01,
    ADC2_EVAL = 2'b10
  } adc2_state_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] count;
    logic [15:0] error;
    logic [15:0] accum;
    logic [15:0] filter;
  } adc2_comp_in_t;

  typedef struct packed {
    logic enable;
    logic start;
    logic convClkTick;
    logic computeStrobe;
    logic secondOfPair;
    logic prechargePolarity;
    logic invertedPrechargeEnable;
    logic guardRingPolarity;
    logic doubleSampleEnable;
    logic previousSampleSource;
    logic [2:0] rightShiftCount;
    logic accumulatorClearCommand;
    logic [2:0] operatingMode;
    logic [2:0] errorCalcMode;
    logic [2:0] thresholdMode;
  } adc2_ctl_out_t;

  typedef struct packed {
    logic valid;
    logic highByte;
    logic [7:0] data;
  } adc2_acc_wr_t;
endpackage : adc2_pkg

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [11:0] busAddr = 12'hF5B;
  logic [7:0] busWdata = 8'h00;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [7:0] busRdata;
  logic convDone = 1'b0;
  logic [9:0] convData = 10'h000;
  logic thresholdInterruptFlag = 1'b0;
  logic accClearDone = 1'b0;
  logic oscTick = 1'b0;
  adc2_pkg::adc2_comp_in_t compIn = {8'h5A, 8'h3C, 16'h0000, 16'h1234, 16'h0000};
  adc2_pkg::adc2_ctl_out_t ctlOut;
  adc2_pkg::adc2_acc_wr_t accWr;
  int n_mismatch = 0;
  int checked = 0;
  adc2_ctrl_regs u_dut (.clock, .reset, .busAddr, .busWdata, .busWrite, .busRead, .busRdata,
    .convDone, .convData, .thresholdInterruptFlag, .accClearDone, .oscTick, .compIn, .ctlOut,
    .accWr);
  always #20 clock = ~clock;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    busAddr <= a;
    busWdata <= d;
    busWrite <= 1'b1;
    @(posedge clock);
    busWrite <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clock);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clock);
    busRead <= 1'b0;
    #1;
    chk(busRdata, exp);
  endtask : rd
  // One finished conversion, then look for the computation strobe
  task conv(input logic [9:0] d, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clock);
    convDone <= 1'b1;
    convData <= d;
    @(posedge clock);
    convDone <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      #1;
      seen = seen | ctlOut.computeStrobe;
      @(posedge clock);
    end
    chk({7'h00, seen}, {7'h00, exp});
  endtask : conv
  // Counts conversion clock ticks over 40 system cycles
  task ticks(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (40)
    begin
      @(posedge clock);
      #1;
      if (ctlOut.convClkTick === 1'b1)
        n++;
    end
    chk(n, exp);
  endtask : ticks
  task end_sim;
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(12'hF5B, 8'h00);
    rd(12'hF54, 8'h00);
    rd(12'hF55, 8'h00);
    rd(12'hF60, 8'h5A);
    rd(12'hF6C, 8'h12);
    wr(12'hF54, 8'hFF);
    rd(12'hF54, 8'hE1);
    wr(12'hF55, 8'hFF);
    rd(12'hF55, 8'hFF);
    @(posedge clock);
    accClearDone <= 1'b1;
    @(posedge clock);
    accClearDone <= 1'b0;
    rd(12'hF55, 8'hF7);
    wr(12'hF56, 8'hFF);
    rd(12'hF56, 8'h7F);
    wr(12'hF50, 8'hFF);
    rd(12'hF50, 8'h00);
    wr(12'hF51, 8'hFF);
    rd(12'hF51, 8'h1F);
    wr(12'hF64, 8'hA5);
    rd(12'hF64, 8'hA5);
    wr(12'hF6C, 8'h5A);
    #1;
    chk({accWr.valid, accWr.highByte, 6'h00}, 8'hC0);
    chk(accWr.data, 8'h5A);
    wr(12'hF5E, 8'hFF);
    rd(12'hF5E, 8'h00);
    wr(12'hF54, 8'h00);
    wr(12'hF55, 8'h00);
    wr(12'hF56, 8'h00);
    wr(12'hF5B, 8'h01);
    rd(12'hF5B, 8'h00);
    wr(12'hF5B, 8'h85);
    rd(12'hF5B, 8'h85);
    conv(10'h2A5, 1'b1);
    rd(12'hF5B, 8'h84);
    rd(12'hF5E, 8'hA5);
    rd(12'hF5F, 8'h02);
    wr(12'hF5B, 8'h81);
    rd(12'hF5C, 8'h40);
    rd(12'hF5D, 8'hA9);
    conv(10'h001, 1'b1);
    rd(12'hF5E, 8'h40);
    rd(12'hF5B, 8'h80);
    wr(12'hF56, 8'h08);
    wr(12'hF5B, 8'hC1);
    conv(10'h000, 1'b1);
    rd(12'hF5B, 8'hC1);
    @(posedge clock);
    thresholdInterruptFlag <= 1'b1;
    conv(10'h000, 1'b1);
    rd(12'hF5B, 8'hC0);
    wr(12'hF56, 8'h00);
    wr(12'hF5B, 8'hC1);
    conv(10'h000, 1'b1);
    rd(12'hF5B, 8'hC1);
    wr(12'hF5B, 8'hC0);
    rd(12'hF5B, 8'hC0);
    @(posedge clock);
    thresholdInterruptFlag <= 1'b0;
    wr(12'hF54, 8'h01);
    wr(12'hF5B, 8'h81);
    conv(10'h000, 1'b0);
    chk({7'h00, ctlOut.secondOfPair}, 8'h01);
    wr(12'hF5B, 8'h81);
    conv(10'h000, 1'b1);
    chk({7'h00, ctlOut.secondOfPair}, 8'h00);
    wr(12'hF54, 8'h00);
    wr(12'hF5B, 8'h90);
    @(posedge clock);
    oscTick <= 1'b1;
    #1;
    chk({7'h00, ctlOut.convClkTick}, 8'h01);
    @(posedge clock);
    oscTick <= 1'b0;
    #1;
    chk({7'h00, ctlOut.convClkTick}, 8'h00);
    wr(12'hF52, 8'h03);
    wr(12'hF5B, 8'h80);
    ticks(8'h0A);
    wr(12'hF5B, 8'h00);
    ticks(8'h00);
    wr(12'hF54, 8'hA1);
    wr(12'hF5B, 8'hD4);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(12'hF54, 8'h00);
    rd(12'hF5B, 8'h00);
    end_sim();
  end
endmodule : tb_top
